// ==== dcm_bench.sv ====
// Self-checking bench for the two counter control registers.
// Assumes dcm_pkg and dcm_top are compiled first; ports driven directly.
`timescale 1ns/1ps
module dcm_bench;
    import dcm_pkg::*;
    typedef struct packed {
        logic [31:0] wd;
        logic [31:0] rd;
    } dcm_row_type;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    dcm_req_type i_req = '0;
    logic i_req_valid = 1'b0;
    logic [31:0] o_rdata, w, e, p0;
    logic [1:0] o_pin_out, o_pin_oe, o_pll_ref, o_port_b_sel;
    logic [5:0] o_pri_pin_a, o_sec_pin_a, o_pri_pin_b, o_sec_pin_b;
    logic [2:0] o_pll_tap_a, o_pll_tap_b;
    logic b;
    int n_mismatch = 0;
    int checks = 0;
    int k;
    dcm_row_type rows [8] = '{'{32'hFFFF_FFFF, 32'h7F80_7E3F},
        '{32'h0000_003F, 32'h0000_003F}, '{32'h0080_0200, 32'h0080_0200},
        '{32'h8100_7E00, 32'h0100_7E00}, '{32'h0180_0020, 32'h0180_0020},
        '{32'h0200_55C0, 32'h0200_5400}, '{32'h0280_8000, 32'h0280_0000},
        '{32'h0300_0015, 32'h0300_0015}};
    dcm_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
        .i_req_valid(i_req_valid), .o_rdata(o_rdata),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pri_pin_a(o_pri_pin_a), .o_sec_pin_a(o_sec_pin_a),
        .o_pri_pin_b(o_pri_pin_b), .o_sec_pin_b(o_sec_pin_b),
        .o_pll_ref(o_pll_ref), .o_pll_tap_a(o_pll_tap_a),
        .o_pll_tap_b(o_pll_tap_b), .o_port_b_sel(o_port_b_sel));
    always #2 i_clk = ~i_clk;
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access, then one idle edge so registered results settle
    task automatic acc(input logic wr, input logic [2:0] sel,
        input logic [31:0] wd);
        i_req = '{wr, sel, wd};
        i_req_valid = 1'b1;
        @(posedge i_clk);
        #1 i_req_valid = 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    // Two reads taken two edges apart: phase grows by twice the step
    task automatic rate(input logic [2:0] sel, input logic [31:0] exp);
        acc(1'b0, sel, '0);
        p0 = o_rdata;
        acc(1'b0, sel, '0);
        check("phase_step", o_rdata - p0, exp);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        check("rst_oe", 32'(o_pin_oe), 32'h0);
        acc(1'b0, DCM_SEL_CTRL_A, '0);
        check("rst_ctrl_a", o_rdata, 32'h0);
        for (int i = 0; i < 32; i++)
        begin
            w = rows[i % 8].wd;
            e = rows[i % 8].rd;
            w[30:26] = 5'(i);
            e[30:26] = 5'(i);
            k = i % 2;
            acc(1'b1, 3'(k), w);
            acc(1'b0, 3'(k), '0);
            check("ctrl", o_rdata, e);
            check("pri", 32'(k ? o_pri_pin_b : o_pri_pin_a), 32'(w[5:0]));
            check("port_b", 32'(o_port_b_sel[k]), 32'(w[5]));
            check("tap", 32'(k ? o_pll_tap_b : o_pll_tap_a), 32'(w[25:23]));
            check("sec", 32'(k ? o_sec_pin_b : o_sec_pin_a),
                i == 5 ? 32'(w[14:9]) : 32'h0);
            check("oe", 32'(o_pin_oe[k]), 32'(i == 4 || i == 5));
        end
        acc(1'b1, DCM_SEL_CTRL_A, 32'h1000_0000);
        acc(1'b1, DCM_SEL_CTRL_B, 32'h0);
        acc(1'b0, DCM_SEL_CTRL_A, '0);
        check("ctrl_a_kept", o_rdata, 32'h1000_0000);
        acc(1'b1, DCM_SEL_FREQ_A, 32'h8000_0000);
        b = o_pin_out[0];
        @(posedge i_clk);
        #1;
        check("nco_toggle", 32'(o_pin_out[0]), 32'(!b));
        check("nco_ref", 32'(o_pll_ref[0]), 32'(!b));
        acc(1'b1, DCM_SEL_FREQ_A, 32'h0000_0010);
        acc(1'b1, DCM_SEL_CTRL_A, 32'h0400_0000);
        check("pll_oe", 32'(o_pin_oe[0]), 32'h0);
        rate(DCM_SEL_PHASE_A, 32'h0000_0020);
        rate(DCM_SEL_PHASE_B, 32'h0000_0000);
        acc(1'b1, DCM_SEL_CTRL_A, 32'h0);
        rate(DCM_SEL_PHASE_A, 32'h0000_0000);
        check("off_ref", 32'(o_pll_ref[0]), 32'h0);
        // Step for about 6 MHz at 250 MHz, inside the advised NCO range
        acc(1'b1, DCM_SEL_FREQ_B, 32'h0624_DD2F);
        acc(1'b1, DCM_SEL_CTRL_B, 32'h0800_0000);
        rate(DCM_SEL_PHASE_B, 32'h0C49_BA5E);
        acc(1'b1, 3'h6, 32'hFFFF_FFFF);
        acc(1'b0, 3'h6, '0);
        check("unmapped", o_rdata, 32'h0);
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        acc(1'b0, DCM_SEL_CTRL_B, '0);
        check("rerst_ctrl_b", o_rdata, 32'h0);
        check("rerst_ref", 32'(o_pll_ref), 32'h0);
        final_report();
    end
endmodule // dcm_bench

// ==== dcm_pkg.sv ====
// Package for the dual counter module control block.
// Assumes a single 250 MHz system clock and a synchronous core register port.
package dcm_pkg;
    // ************************************************************
    // Control register layout
    // ************************************************************
    localparam int DCM_MODE_HI = 30;
    localparam int DCM_MODE_LO = 26;
    localparam int DCM_TAP_HI = 25;
    localparam int DCM_TAP_LO = 23;
    localparam int DCM_SEC_HI = 14;
    localparam int DCM_SEC_LO = 9;
    localparam int DCM_PRI_HI = 5;
    localparam int DCM_PRI_LO = 0;
    localparam logic [31:0] DCM_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DCM_CTRL_USED = 32'h7F80_7E3F;
    localparam logic [31:0] DCM_ZERO32 = 32'h0000_0000;
    // ************************************************************
    // Register select codes
    // ************************************************************
    localparam logic [2:0] DCM_SEL_CTRL_A = 3'h0;
    localparam logic [2:0] DCM_SEL_CTRL_B = 3'h1;
    localparam logic [2:0] DCM_SEL_FREQ_A = 3'h2;
    localparam logic [2:0] DCM_SEL_FREQ_B = 3'h3;
    localparam logic [2:0] DCM_SEL_PHASE_A = 3'h4;
    localparam logic [2:0] DCM_SEL_PHASE_B = 3'h5;
    // ************************************************************
    // Modes
    // ************************************************************
    localparam logic [4:0] DCM_MODE_OFF = 5'h00;
    localparam logic [4:0] DCM_MODE_PLL_LO = 5'h01;
    localparam logic [4:0] DCM_MODE_PLL_HI = 5'h03;
    localparam logic [4:0] DCM_MODE_NCO = 5'h04;
    localparam logic [4:0] DCM_MODE_NCO_DIFF = 5'h05;
    localparam int DCM_PLL_MULT = 16;
    localparam int DCM_TAP_MAX_DIV = 128;
    localparam int DCM_PRI_PORT_BIT = 5;
    localparam int DCM_NCO_BIT = 31;

    typedef struct packed {
        logic [4:0] mode;
        logic [2:0] tap;
        logic [5:0] sec_pin;
        logic [5:0] pri_pin;
    } dcm_ctrl_type;

    typedef struct packed {
        logic wr;
        logic [2:0] sel;
        logic [31:0] wdata;
    } dcm_req_type;
endpackage

// ==== dcm_top.sv ====
// Two counter modules of one core: control, frequency, phase registers.
// Assumes core register accesses are synchronous; the analogue PLL is
// outside, fed by o_pll_ref and tap code.
// Function
// - Two identical counters, each set only by its own control, frequency and phase registers
// - Each drives up to two pins; accumulates frequency into phase per clock in modes 1 to 5
// - Control layout: mode 30:26, tap 25:23, secondary 14:9, primary low bits
// - Primary select top bit zero picks port A; one is reserved port B
// - Writing zero disables the counter: no pin output, no accumulation
// - Secondary select has no effect in modes without a second pin
// - Tap code 0 divides VCO by 128, each step halves, 7 divides by 1
// - Mode field picks one of 32 modes, per counter
// - Modes 1 to 3 accumulate; phase bit 31 feeds the PLL reference
// - The PLL multiplies its reference by 16 in the VCO
// - A new control value takes effect at once
// - Modes 4 and 5 are the numerically controlled oscillator modes; mode 5 is differential
// - Reading a control register returns its value with no side effect
`timescale 1ns/1ps
module dcm_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire dcm_pkg::dcm_req_type i_req,
    input wire logic i_req_valid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_pin_out,
    output logic [1:0] o_pin_oe,
    output logic [5:0] o_pri_pin_a,
    output logic [5:0] o_sec_pin_a,
    output logic [5:0] o_pri_pin_b,
    output logic [5:0] o_sec_pin_b,
    output logic [1:0] o_pll_ref,
    output logic [2:0] o_pll_tap_a,
    output logic [2:0] o_pll_tap_b,
    output logic [1:0] o_port_b_sel
);
    import dcm_pkg::*;

    // ************************************************************
    // Register decode
    // ************************************************************
    logic [31:0] ctrl [2];
    logic [31:0] freq [2];
    logic [31:0] phase [2];
    wire wr_ctrl_a = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_CTRL_A;
    wire wr_ctrl_b = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_CTRL_B;
    wire wr_freq_a = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_FREQ_A;
    wire wr_freq_b = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_FREQ_B;
    wire wr_ph_a = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_PHASE_A;
    wire wr_ph_b = i_req_valid && i_req.wr && i_req.sel == DCM_SEL_PHASE_B;
    wire [1:0] wr_ctrl = {wr_ctrl_b, wr_ctrl_a};
    wire [1:0] wr_freq = {wr_freq_b, wr_freq_a};
    wire [1:0] wr_ph = {wr_ph_b, wr_ph_a};
    wire [31:0] masked_wdata = i_req.wdata & DCM_CTRL_USED;

    // Control value in effect this cycle: a write acts at once
    logic [31:0] eff_ctrl [2];
    dcm_ctrl_type fld [2];
    logic [1:0] accum_en;
    logic [1:0] nco_on;
    logic [1:0] enabled;
    logic [31:0] next_phase [2];

    for (genvar k = 0; k < 2; k++)
    begin : g_cnt
        assign eff_ctrl[k] = wr_ctrl[k] ? masked_wdata : ctrl[k];
        assign fld[k].mode = eff_ctrl[k][DCM_MODE_HI:DCM_MODE_LO];
        assign fld[k].tap = eff_ctrl[k][DCM_TAP_HI:DCM_TAP_LO];
        assign fld[k].sec_pin = eff_ctrl[k][DCM_SEC_HI:DCM_SEC_LO];
        assign fld[k].pri_pin = eff_ctrl[k][DCM_PRI_HI:DCM_PRI_LO];
        assign enabled[k] = fld[k].mode != DCM_MODE_OFF;
        assign nco_on[k] = fld[k].mode == DCM_MODE_NCO
            || fld[k].mode == DCM_MODE_NCO_DIFF;
        assign accum_en[k] = (fld[k].mode >= DCM_MODE_PLL_LO
            && fld[k].mode <= DCM_MODE_PLL_HI) || nco_on[k];
        assign next_phase[k] = wr_ph[k] ? i_req.wdata
            : accum_en[k] ? 32'(phase[k] + freq[k]) : phase[k];

        always_ff @(posedge i_clk)
        begin
            if (i_sys_rst)
            begin
                ctrl[k] <= DCM_CTRL_RESET;
                freq[k] <= DCM_ZERO32;
                phase[k] <= DCM_ZERO32;
            end
            else
            begin
                if (wr_ctrl[k])
                    ctrl[k] <= masked_wdata;
                if (wr_freq[k])
                    freq[k] <= i_req.wdata;
                phase[k] <= next_phase[k];
            end
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    logic [31:0] next_rdata;
    always_comb
    begin
        case (i_req.sel)
            DCM_SEL_CTRL_A: next_rdata = ctrl[0];
            DCM_SEL_CTRL_B: next_rdata = ctrl[1];
            DCM_SEL_FREQ_A: next_rdata = freq[0];
            DCM_SEL_FREQ_B: next_rdata = freq[1];
            DCM_SEL_PHASE_A: next_rdata = phase[0];
            DCM_SEL_PHASE_B: next_rdata = phase[1];
            default: next_rdata = DCM_ZERO32;
        endcase
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // NCO pin shows phase bit 31; differential mode also passes the
    // secondary select to o_sec_pin_a/b, the only use of that select here
    wire [1:0] next_oe = {nco_on[1], nco_on[0]};
    wire [1:0] next_pin = {next_phase[1][DCM_NCO_BIT],
        next_phase[0][DCM_NCO_BIT]};
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= DCM_ZERO32;
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_pri_pin_a <= '0;
            o_sec_pin_a <= '0;
            o_pri_pin_b <= '0;
            o_sec_pin_b <= '0;
            o_pll_ref <= '0;
            o_pll_tap_a <= '0;
            o_pll_tap_b <= '0;
            o_port_b_sel <= '0;
        end
        else
        begin
            o_rdata <= (i_req_valid && !i_req.wr) ? next_rdata : o_rdata;
            o_pin_out <= next_pin & next_oe;
            o_pin_oe <= next_oe;
            o_pri_pin_a <= fld[0].pri_pin;
            o_pri_pin_b <= fld[1].pri_pin;
            o_sec_pin_a <= fld[0].mode == DCM_MODE_NCO_DIFF
                ? fld[0].sec_pin : '0;
            o_sec_pin_b <= fld[1].mode == DCM_MODE_NCO_DIFF
                ? fld[1].sec_pin : '0;
            o_pll_ref <= {next_phase[1][DCM_NCO_BIT] & enabled[1],
                next_phase[0][DCM_NCO_BIT] & enabled[0]};
            o_pll_tap_a <= fld[0].tap;
            o_pll_tap_b <= fld[1].tap;
            o_port_b_sel <= {fld[1].pri_pin[DCM_PRI_PORT_BIT],
                fld[0].pri_pin[DCM_PRI_PORT_BIT]};
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Consequents look one edge on, where the registered outputs settle
    AST_ZERO_STOPS: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        wr_ctrl_a && i_req.wdata == DCM_ZERO32 && !wr_ph_a
        |=> !o_pin_oe[0] && $stable(phase[0]))
        else $error("Counter A still active after zero write");
    AST_ACCUM: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        accum_en[0] && !wr_ph_a
        |=> phase[0] == 32'($past(phase[0]) + $past(freq[0])))
        else $error("Counter A phase did not accumulate");
    AST_IMMEDIATE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        wr_ctrl_b
        |=> o_pll_tap_b == $past(i_req.wdata[DCM_TAP_HI:DCM_TAP_LO]))
        else $error("Counter B tap not applied at once");
    AST_READBACK: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_req_valid && !i_req.wr && i_req.sel == DCM_SEL_CTRL_A
        |=> o_rdata == $past(ctrl[0]) && ctrl[0] == $past(ctrl[0]))
        else $error("Control A read wrong or disturbed");
    AST_SEC_IGNORED: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        fld[0].mode != DCM_MODE_NCO_DIFF |=> o_sec_pin_a == '0)
        else $error("Secondary select leaked");
    AST_RESET_ZERO: assert property (@(posedge i_clk)
        i_sys_rst |=> ctrl[0] == DCM_ZERO32 && ctrl[1] == DCM_ZERO32)
        else $error("Control not cleared by reset");
    AST_NCO_PIN: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        nco_on[1]
        |=> o_pin_oe[1] && o_pin_out[1] == phase[1][DCM_NCO_BIT])
        else $error("Counter B NCO pin wrong");
    AST_PORT_SEL: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        wr_ctrl_a ##1 !wr_ctrl_a
        |-> o_port_b_sel[0] == ctrl[0][DCM_PRI_PORT_BIT])
        else $error("Port select mismatch");
    AST_INDEP: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        wr_ctrl_a && !wr_ctrl_b |=> $stable(ctrl[1]))
        else $error("Counter B changed by A write");
    AST_PIN_IDLE: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        !nco_on[0]
        |=> o_pin_oe[0] == 1'b0 && o_pin_out[0] == 1'b0)
        else $error("Counter A drives its pin outside NCO modes");
    AST_REF_OFF: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        fld[1].mode == DCM_MODE_OFF
        |=> o_pll_ref[1] == 1'b0)
        else $error("Counter B reference runs while disabled");
    AST_UNMAPPED_READ: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_req_valid && !i_req.wr && i_req.sel > DCM_SEL_PHASE_B
        |=> o_rdata == DCM_ZERO32)
        else $error("Unmapped select read not zero");
    AST_RESET_OUT: assert property (@(posedge i_clk)
        i_sys_rst
        |=> o_pin_oe == 2'h0 && o_pll_ref == 2'h0 && o_rdata == DCM_ZERO32)
        else $error("Outputs not cleared by reset");
    AST_PORT_SEL_B: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        wr_ctrl_b ##1 !wr_ctrl_b
        |-> o_port_b_sel[1] == ctrl[1][DCM_PRI_PORT_BIT])
        else $error("Counter B port select mismatch");
    AST_SEC_IGNORED_B: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        fld[1].mode != DCM_MODE_NCO_DIFF
        |=> o_sec_pin_b == '0)
        else $error("Counter B secondary select leaked");
endmodule // dcm_top
